/* File: ubm_consts.svh */
/*
  Constants of the USB bus-master transfer engine: register byte offsets,
  control and interrupt bit positions, reset values.
  Assumes it is included once per compilation unit by bare name.
*/
`ifndef UBM_CONSTS_SVH
`define UBM_CONSTS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define UBM_OFS_SETTINGS   8'h00
`define UBM_OFS_RD_START   8'h04
`define UBM_OFS_RD_END     8'h08
`define UBM_OFS_RD_CUR     8'h0c
`define UBM_OFS_WR_START   8'h10
`define UBM_OFS_WR_END     8'h14
`define UBM_OFS_WR_CUR     8'h18
`define UBM_OFS_EXPIRE     8'h1c
`define UBM_OFS_STATUS     8'h20
`define UBM_OFS_IRQ_STS    8'h24
`define UBM_OFS_IRQ_EN     8'h28

// ----------------------------------------------------------------------
// master_settings bits
// ----------------------------------------------------------------------
`define UBM_SET_READ_RUN      0
`define UBM_SET_READ_STOP     1
`define UBM_SET_READ_INIT     2
`define UBM_SET_EOP_EN        3
`define UBM_SET_WRITE_RUN     4
`define UBM_SET_WRITE_STOP    5
`define UBM_SET_WRITE_INIT    6

// ----------------------------------------------------------------------
// Interrupt status / enable bits, expire control, master_status
// ----------------------------------------------------------------------
`define UBM_IRQ_READ_END      0
`define UBM_IRQ_WRITE_END     1
`define UBM_IRQ_START_NEEDED  2
`define UBM_IRQ_WRITE_EXPIRE  3
`define UBM_IRQ_W             4
`define UBM_EXP_EN_BIT        31
`define UBM_STS_RD_EMPTY      0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define UBM_RST_WORD     32'h0000_0000
`define UBM_RST_IRQ      4'h0
`define UBM_RST_PRESET   16'h0000

`endif

/* File: ubm_pkg.sv */
/*
  Types of the USB bus-master transfer engine: engine states and the
  byte-wide memory request carrier.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package ubm_pkg;

  // --------------------------------------------------------------------
  // Engine states, one-hot
  // --------------------------------------------------------------------
  typedef enum logic [2:0] {
    UBM_R_IDLE  = 3'b001,
    UBM_R_FETCH = 3'b010,
    UBM_R_PUSH  = 3'b100
  } ubm_rd_state_t;

  typedef enum logic [2:0] {
    UBM_W_IDLE  = 3'b001,
    UBM_W_TAKE  = 3'b010,
    UBM_W_STORE = 3'b100
  } ubm_wr_state_t;

  // --------------------------------------------------------------------
  // Memory request: held until the memory answers with its ack
  // --------------------------------------------------------------------
  typedef struct packed {
    logic req;
    logic we;
    logic [31:0] addr;
    logic [7:0] data;
  } ubm_mem_req_t;

endpackage : ubm_pkg

/* File: ubm_expire_timer.sv */
/*
  Write-side inactivity timer of the bus-master transfer engine.
  Assumes run, reload and preset are synchronous to hclk.
*/
module ubm_expire_timer #(
  parameter int W = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic run,
  input wire logic reload,
  input wire logic [W-1:0] preset,
  output logic expired
);

  logic [W-1:0] count_q;

  // ----------------------------------------------------------------------
  // Down counter
  // ----------------------------------------------------------------------
  // Parked at the preset while idle; each received packet restarts the count
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_q <= '0;
    end else if (!run || reload) begin
      count_q <= preset;
    end else if (count_q != '0) begin
      count_q <= count_q - 1'b1;
    end
  end

  // Level until the engine leaves its running states or a received packet reloads the count
  assign expired = run && !reload && (count_q == '0);

endmodule : ubm_expire_timer

/* File: ubm_dma_top.sv */
/*
  Bus-master transfer engine between memory and the endpoints of a USB
  device core, with an AHB-Lite register slave.
  Assumes a single hclk domain, a byte-wide memory port per direction that
  holds each request until ack, and an endpoint FIFO with valid/ready.
*/
// Chosen here: the AHB-Lite slave port and the placing of the registers.
`include "ubm_consts.svh"

module ubm_dma_top
  import ubm_pkg::*;
#(
  parameter int TMR_W = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output ubm_mem_req_t rd_mem,
  input wire logic rd_mem_ack,
  input wire logic [7:0] rd_mem_rdata,
  output ubm_mem_req_t wr_mem,
  input wire logic wr_mem_ack,
  output logic ep_in_valid,
  output logic [7:0] ep_in_data,
  output logic ep_in_last,
  input wire logic ep_in_ready,
  input wire logic ep_in_empty,
  input wire logic ep_out_valid,
  input wire logic [7:0] ep_out_data,
  output logic ep_out_ready,
  input wire logic ep_out_pkt_ok,
  output logic usb_irq_out
);

  // ----------------------------------------------------------------------
  // Register bus slave
  // ----------------------------------------------------------------------
  logic wr_pend_q;
  logic [7:0] wofs_q;
  logic [31:0] rd_start_q, rd_end_q, rd_cur_q;
  logic [31:0] wr_start_q, wr_end_q, wr_cur_q, wr_ptr_q;
  logic [31:0] expire_q;
  logic eop_en_q, read_run_q, write_run_q, read_stop_q, write_stop_q;
  logic [`UBM_IRQ_W-1:0] irq_sts_q, irq_en_q, irq_set;
  ubm_rd_state_t rd_st_q;
  ubm_wr_state_t wr_st_q;
  logic [7:0] rd_byte_q, wr_byte_q;
  logic expired;

  // Decode an offset once for both the write and the read path
  function automatic logic hit(input logic [7:0] ofs, input logic [7:0] reg_ofs);
    hit = (ofs == reg_ofs);
  endfunction : hit

  wire logic take_addr = hsel && htrans[1] && hready;
  wire logic [7:0] aofs = {haddr[7:2], 2'b00};
  wire logic sw_wr = wr_pend_q;
  wire logic [31:0] wd = hwdata;

  // Single-word register writes land in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wofs_q <= 8'h00;
    end else if (hready) begin
      wr_pend_q <= take_addr && hwrite;
      wofs_q <= aofs;
    end
  end

  // Every access answers at once with OKAY; unmapped reads return zero
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Read mux, registered at the address phase so hrdata is a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= `UBM_RST_WORD;
    end else if (take_addr && !hwrite) begin
      unique case (1'b1)
        hit(aofs, `UBM_OFS_SETTINGS): hrdata <= {25'h0, 2'b00, write_run_q, eop_en_q, 2'b00,
                                                 read_run_q};
        hit(aofs, `UBM_OFS_RD_START): hrdata <= rd_start_q;
        hit(aofs, `UBM_OFS_RD_END): hrdata <= rd_end_q;
        hit(aofs, `UBM_OFS_RD_CUR): hrdata <= rd_cur_q;
        hit(aofs, `UBM_OFS_WR_START): hrdata <= wr_start_q;
        hit(aofs, `UBM_OFS_WR_END): hrdata <= wr_end_q;
        hit(aofs, `UBM_OFS_WR_CUR): hrdata <= wr_cur_q;
        hit(aofs, `UBM_OFS_EXPIRE): hrdata <= expire_q;
        hit(aofs, `UBM_OFS_STATUS): hrdata <= {31'h0, ep_in_empty};
        hit(aofs, `UBM_OFS_IRQ_STS): hrdata <= {28'h0, irq_sts_q};
        hit(aofs, `UBM_OFS_IRQ_EN): hrdata <= {28'h0, irq_en_q};
        default: hrdata <= `UBM_RST_WORD;
      endcase
    end
  end

  // Plain configuration words
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_start_q <= `UBM_RST_WORD;
      rd_end_q <= `UBM_RST_WORD;
      wr_start_q <= `UBM_RST_WORD;
      wr_end_q <= `UBM_RST_WORD;
      expire_q <= `UBM_RST_WORD;
      irq_en_q <= `UBM_RST_IRQ;
      eop_en_q <= 1'b0;
    end else if (sw_wr) begin
      if (hit(wofs_q, `UBM_OFS_RD_START)) rd_start_q <= wd;
      if (hit(wofs_q, `UBM_OFS_RD_END)) rd_end_q <= wd;
      if (hit(wofs_q, `UBM_OFS_WR_START)) wr_start_q <= wd;
      if (hit(wofs_q, `UBM_OFS_WR_END)) wr_end_q <= wd;
      if (hit(wofs_q, `UBM_OFS_EXPIRE)) expire_q <= wd;
      if (hit(wofs_q, `UBM_OFS_IRQ_EN)) irq_en_q <= wd[`UBM_IRQ_W-1:0];
      if (hit(wofs_q, `UBM_OFS_SETTINGS)) eop_en_q <= wd[`UBM_SET_EOP_EN];
    end
  end

  wire logic set_wr = sw_wr && hit(wofs_q, `UBM_OFS_SETTINGS);
  wire logic rd_go = set_wr && wd[`UBM_SET_READ_RUN] && !read_run_q;
  wire logic wr_go = set_wr && wd[`UBM_SET_WRITE_RUN] && !write_run_q;
  wire logic rd_init = set_wr && wd[`UBM_SET_READ_INIT];
  wire logic wr_init = set_wr && wd[`UBM_SET_WRITE_INIT];

  // ----------------------------------------------------------------------
  // Interrupt status and output
  // ----------------------------------------------------------------------
  // Write-one-to-clear; a new event in the same cycle wins over the clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_sts_q <= `UBM_RST_IRQ;
    end else begin
      irq_sts_q <= (irq_sts_q & ~((sw_wr && hit(wofs_q, `UBM_OFS_IRQ_STS)) ?
                   wd[`UBM_IRQ_W-1:0] : `UBM_RST_IRQ)) | irq_set;
    end
  end

  // Combinational so enabling over a pending bit asserts in the same cycle
  assign usb_irq_out = |(irq_sts_q & irq_en_q);

  // ----------------------------------------------------------------------
  // Read engine: memory to IN endpoint
  // ----------------------------------------------------------------------
  wire logic rd_at_end = (rd_cur_q == rd_end_q);
  wire logic rd_done = (rd_st_q == UBM_R_PUSH) && ep_in_ready && rd_at_end;

  // Run bit: set by software, cleared on completion or stop, never by USB events
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      read_run_q <= 1'b0;
      read_stop_q <= 1'b0;
    end else if (rd_init) begin
      read_run_q <= 1'b0;
      read_stop_q <= 1'b0;
    end else if (rd_go) begin
      read_run_q <= 1'b1;
      read_stop_q <= 1'b0;
    end else begin
      if (set_wr && wd[`UBM_SET_READ_STOP] && read_run_q) read_stop_q <= 1'b1;
      if (rd_done || (read_stop_q && rd_st_q != UBM_R_FETCH)) begin
        read_run_q <= 1'b0;
        read_stop_q <= 1'b0;
      end
    end
  end

  // Stop is honoured only between memory accesses so no ack is orphaned
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_st_q <= UBM_R_IDLE;
      rd_cur_q <= `UBM_RST_WORD;
      rd_byte_q <= 8'h00;
    end else if (rd_init) begin
      rd_st_q <= UBM_R_IDLE;
      rd_cur_q <= `UBM_RST_WORD;
    end else begin
      unique case (rd_st_q)
        UBM_R_IDLE: begin
          if (rd_go) begin
            rd_cur_q <= rd_start_q;
            rd_st_q <= UBM_R_FETCH;
          end
        end
        UBM_R_FETCH: begin
          if (rd_mem_ack) begin
            rd_byte_q <= rd_mem_rdata;
            rd_st_q <= read_stop_q ? UBM_R_IDLE : UBM_R_PUSH;
          end
        end
        UBM_R_PUSH: begin
          if (read_stop_q) begin
            rd_st_q <= UBM_R_IDLE;
          end else if (ep_in_ready) begin
            if (rd_at_end) begin
              rd_st_q <= UBM_R_IDLE;
            end else begin
              rd_cur_q <= rd_cur_q + 32'h1;
              rd_st_q <= UBM_R_FETCH;
            end
          end
        end
      endcase
    end
  end

  assign rd_mem = '{req: rd_st_q == UBM_R_FETCH, we: 1'b0, addr: rd_cur_q, data: 8'h00};
  assign ep_in_valid = (rd_st_q == UBM_R_PUSH) && !read_stop_q;
  assign ep_in_data = rd_byte_q;
  // Only eop mode closes a short packet; otherwise bytes wait for a full one
  assign ep_in_last = ep_in_valid && eop_en_q && rd_at_end;

  // ----------------------------------------------------------------------
  // Write engine: OUT endpoint to memory
  // ----------------------------------------------------------------------
  wire logic exp_en = expire_q[`UBM_EXP_EN_BIT];
  wire logic wr_at_end = (wr_ptr_q == wr_end_q);
  wire logic wr_store_ok = (wr_st_q == UBM_W_STORE) && wr_mem_ack;
  wire logic wr_finish_end = wr_store_ok && wr_at_end;
  // Expiry ends only with no byte held, so the held byte is flushed first
  wire logic wr_finish_exp = expired && !wr_finish_end &&
                             ((wr_st_q == UBM_W_TAKE && !ep_out_valid) || wr_store_ok);
  wire logic wr_stop_now = write_stop_q && (wr_st_q != UBM_W_STORE || wr_mem_ack);

  // Timer reloads on every packet that reaches the endpoint
  ubm_expire_timer #(
    .W(TMR_W)
  ) u_timer (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(exp_en && wr_st_q != UBM_W_IDLE),
    .reload(ep_out_pkt_ok),
    .preset(expire_q[TMR_W-1:0]),
    .expired(expired)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      write_run_q <= 1'b0;
      write_stop_q <= 1'b0;
    end else if (wr_init) begin
      write_run_q <= 1'b0;
      write_stop_q <= 1'b0;
    end else if (wr_go) begin
      write_run_q <= 1'b1;
      write_stop_q <= 1'b0;
    end else begin
      if (set_wr && wd[`UBM_SET_WRITE_STOP] && write_run_q) write_stop_q <= 1'b1;
      if (wr_finish_end || wr_finish_exp || wr_stop_now || (write_stop_q && !write_run_q)) begin
        write_run_q <= 1'b0;
        write_stop_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_st_q <= UBM_W_IDLE;
      wr_ptr_q <= `UBM_RST_WORD;
      wr_cur_q <= `UBM_RST_WORD;
      wr_byte_q <= 8'h00;
    end else if (wr_init) begin
      wr_st_q <= UBM_W_IDLE;
      wr_ptr_q <= `UBM_RST_WORD;
      wr_cur_q <= `UBM_RST_WORD;
    end else begin
      if (wr_store_ok) wr_cur_q <= wr_ptr_q;
      unique case (wr_st_q)
        UBM_W_IDLE: begin
          if (wr_go) begin
            wr_ptr_q <= wr_start_q;
            wr_st_q <= UBM_W_TAKE;
          end
        end
        UBM_W_TAKE: begin
          if (wr_stop_now || wr_finish_exp) begin
            wr_st_q <= UBM_W_IDLE;
          end else if (ep_out_valid) begin
            wr_byte_q <= ep_out_data;
            wr_st_q <= UBM_W_STORE;
          end
        end
        UBM_W_STORE: begin
          if (wr_mem_ack) begin
            if (wr_finish_end || wr_finish_exp || write_stop_q) begin
              wr_st_q <= UBM_W_IDLE;
            end else begin
              wr_ptr_q <= wr_ptr_q + 32'h1;
              wr_st_q <= UBM_W_TAKE;
            end
          end
        end
      endcase
    end
  end

  assign wr_mem = '{req: wr_st_q == UBM_W_STORE, we: 1'b1, addr: wr_ptr_q, data: wr_byte_q};
  assign ep_out_ready = (wr_st_q == UBM_W_TAKE) && !write_stop_q && !wr_finish_exp;

  // ----------------------------------------------------------------------
  // Interrupt events
  // ----------------------------------------------------------------------
  always_comb begin
    irq_set = `UBM_RST_IRQ;
    irq_set[`UBM_IRQ_READ_END] = rd_done && !read_stop_q;
    irq_set[`UBM_IRQ_WRITE_END] = wr_finish_end && !write_stop_q;
    irq_set[`UBM_IRQ_START_NEEDED] = ep_out_pkt_ok && !write_run_q;
    irq_set[`UBM_IRQ_WRITE_EXPIRE] = wr_finish_exp && !write_stop_q;
  end

endmodule : ubm_dma_top

/* File: ubm_far_model.sv */
/*
  Far side of the engine: byte memory with stalls, IN FIFO sink, OUT source.
  Assumes the bench fills the OUT source with push and empties the sink via n_in.
*/
// ----------
// Far model
// ----------
module ubm_far_model
  import ubm_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire ubm_mem_req_t rd_mem,
  output logic rd_mem_ack,
  output logic [7:0] rd_mem_rdata,
  input wire ubm_mem_req_t wr_mem,
  output logic wr_mem_ack,
  input wire logic ep_in_valid,
  input wire logic [7:0] ep_in_data,
  input wire logic ep_in_last,
  output logic ep_in_ready,
  output logic ep_in_empty,
  output logic ep_out_valid,
  output logic [7:0] ep_out_data,
  input wire logic ep_out_ready,
  output logic ep_out_pkt_ok
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [256];
  logic [7:0] in_b [256];
  logic in_l [256];
  logic [7:0] out_b [256];
  logic [7:0] lf = 8'h20;
  logic [7:0] gone = 8'h00;
  int n_in = 0;
  int hd = 0;
  int tl = 0;
  // Stall pattern decides when the FIFO takes a byte
  assign ep_in_ready = lf[1];
  assign ep_in_empty = (n_in == 0);
  assign ep_out_valid = (hd != tl);
  // A drained OUT line shows the inverse of the last byte, so stale data cannot pass
  assign ep_out_data = ep_out_valid ? out_b[hd[7:0]] : ~gone;
  // Known memory contents keep fetched bytes free of unknowns
  initial begin
    ep_out_pkt_ok = 1'b0;
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i);
    end
  end
  // Memory answers one request per port after a pattern-driven stall
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_mem_ack <= 1'b0;
      wr_mem_ack <= 1'b0;
      rd_mem_rdata <= 8'h00;
    end else begin
      lf <= {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
      rd_mem_ack <= rd_mem.req && !rd_mem_ack && lf[0];
      rd_mem_rdata <= (rd_mem.req && lf[0]) ? mem[rd_mem.addr[7:0]] : ~rd_mem_rdata;
      wr_mem_ack <= wr_mem.req && !wr_mem_ack && lf[2];
      if (wr_mem.req && !wr_mem_ack && lf[2]) begin
        mem[wr_mem.addr[7:0]] <= wr_mem.data;
      end
      if (ep_in_valid && ep_in_ready) begin
        in_b[n_in[7:0]] <= ep_in_data;
        in_l[n_in[7:0]] <= ep_in_last;
        n_in <= n_in + 1;
      end
      if (ep_out_valid && ep_out_ready) begin
        gone <= out_b[hd[7:0]];
        hd <= hd + 1;
      end
    end
  end
  task automatic push(input logic [7:0] b);
    @(posedge hclk);
    out_b[tl[7:0]] <= b;
    tl <= tl + 1;
  endtask : push
  task automatic send_pkt();
    @(posedge hclk);
    ep_out_pkt_ok <= 1'b1;
    @(posedge hclk);
    ep_out_pkt_ok <= 1'b0;
  endtask : send_pkt
endmodule : ubm_far_model

/* File: ubm_dma_properties.sv */
/*
  Port checker of the bus-master engine.
  Assumes one hclk domain and the byte req/ack memory handshake.
*/
// ----------
// Checker
// ----------
module ubm_dma_checker
  import ubm_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire ubm_mem_req_t rd_mem,
  input wire logic rd_mem_ack,
  input wire logic [7:0] rd_mem_rdata,
  input wire ubm_mem_req_t wr_mem,
  input wire logic wr_mem_ack,
  input wire logic ep_in_valid,
  input wire logic [7:0] ep_in_data,
  input wire logic ep_in_last,
  input wire logic ep_in_ready,
  input wire logic ep_out_valid,
  input wire logic [7:0] ep_out_data,
  input wire logic ep_out_ready,
  input wire logic usb_irq_out
);
  // All checks share hclk and sleep while reset is low
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_bus_zero_wait: assert property (hreadyout && !hresp)
    else $error("register bus not zero-wait OKAY");
  a_rd_req_hold: assert property (rd_mem.req && !rd_mem_ack |=> rd_mem.req && $stable(rd_mem.addr))
    else $error("read request dropped or moved");
  a_wr_req_hold: assert property (wr_mem.req && !wr_mem_ack |=> wr_mem.req && $stable(wr_mem))
    else $error("write request dropped or moved");
  a_mem_dir: assert property ((!rd_mem.req || !rd_mem.we) && (!wr_mem.req || wr_mem.we))
    else $error("memory request direction wrong");
  a_push_after_ack: assert property ($rose(ep_in_valid) |-> $past(rd_mem_ack))
    else $error("IN byte offered without a fetch");
  a_push_data: assert property (rd_mem_ack ##1 ep_in_valid |-> ep_in_data == $past(rd_mem_rdata))
    else $error("IN byte differs from fetched byte");
  a_fetch_or_push: assert property (!(ep_in_valid && rd_mem.req))
    else $error("fetch while a byte is pending");
  a_store_taken: assert property (ep_out_valid && ep_out_ready |=>
    wr_mem.req && wr_mem.data == $past(ep_out_data))
    else $error("OUT byte not stored");
  a_take_when_free: assert property (wr_mem.req |-> !ep_out_ready)
    else $error("OUT byte taken while a store is pending");
  a_last_in_push: assert property (ep_in_last |-> ep_in_valid)
    else $error("last flag without a byte");
  a_idle_after_last: assert property (ep_in_valid && ep_in_ready && ep_in_last |=>
    !rd_mem.req && !ep_in_valid)
    else $error("read engine kept going after the last byte");
  c_short_close: cover property (ep_in_valid && ep_in_ready && ep_in_last);
  c_store: cover property (wr_mem.req && wr_mem_ack);
  c_irq: cover property ($rose(usb_irq_out));
endmodule : ubm_dma_checker

bind ubm_dma_top ubm_dma_checker chk_u (.hclk, .hresetn, .hreadyout, .hresp, .rd_mem,
  .rd_mem_ack, .rd_mem_rdata, .wr_mem, .wr_mem_ack, .ep_in_valid, .ep_in_data, .ep_in_last,
  .ep_in_ready, .ep_out_valid, .ep_out_data, .ep_out_ready, .usb_irq_out);

/* File: testbench.sv */
/*
  Self-checking bench of ubm_dma_top with an AHB-Lite register master.
  Assumes the design package, constants header and far model are compiled first.
*/
`include "ubm_consts.svh"
// ----------
// Bench
// ----------
module testbench;
  import ubm_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] SET = `UBM_OFS_SETTINGS;
  localparam logic [7:0] IS = `UBM_OFS_IRQ_STS;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rv;
  logic [7:0] seed = 8'h20;
  logic [7:0] exp_w [8];
  logic hreadyout, hresp, rd_mem_ack, wr_mem_ack, ep_in_valid, ep_in_last, ep_in_ready;
  logic ep_in_empty, ep_out_valid, ep_out_ready, ep_out_pkt_ok, usb_irq_out;
  logic [7:0] rd_mem_rdata, ep_in_data, ep_out_data;
  ubm_mem_req_t rd_mem, wr_mem;
  int num_errors = 0;
  int checks_done = 0;
  // 100 MHz bus clock
  always #5 hclk = ~hclk;
  ubm_dma_top dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hrdata, .hresp, .rd_mem, .rd_mem_ack, .rd_mem_rdata,
    .wr_mem, .wr_mem_ack, .ep_in_valid, .ep_in_data, .ep_in_last, .ep_in_ready, .ep_in_empty,
    .ep_out_valid, .ep_out_data, .ep_out_ready, .ep_out_pkt_ok, .usb_irq_out);
  ubm_far_model far_u (.hclk, .hresetn, .rd_mem, .rd_mem_ack, .rd_mem_rdata, .wr_mem,
    .wr_mem_ack, .ep_in_valid, .ep_in_data, .ep_in_last, .ep_in_ready, .ep_in_empty,
    .ep_out_valid, .ep_out_data, .ep_out_ready, .ep_out_pkt_ok);
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr
  function automatic logic [31:0] bitw(input int b);
    return 32'h1 << b;
  endfunction : bitw
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // One single transfer; the master waits for hready rather than assuming zero waits
  task automatic bus(input logic wr, input logic [7:0] ofs, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, ofs};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rv = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
    bus(1'b1, ofs, d);
  endtask : wr
  task automatic rd(input logic [7:0] ofs, input logic [31:0] exp);
    bus(1'b0, ofs, 32'h0);
    chk(rv, exp);
  endtask : rd
  // Poll a run bit until the engine drops it; bounded so a stuck engine is reported
  task automatic wait_run(input int b);
    for (int i = 0; i < 200; i++) begin
      bus(1'b0, SET, 32'h0);
      if (rv[b] === 1'b0) break;
    end
    chk(32'(rv[b]), 32'h0);
  endtask : wait_run
  task automatic fill(input int n);
    for (int i = 0; i < n; i++) begin
      seed = lfsr(seed);
      exp_w[i] = seed;
      far_u.push(seed);
    end
  endtask : fill
  task automatic run_read(input int n, input logic eop);
    for (int i = 0; i < n; i++) begin
      seed = lfsr(seed);
      far_u.mem[16 + i] = seed;
    end
    wr(IS, 32'hf);
    wr(`UBM_OFS_RD_START, 32'h10);
    wr(`UBM_OFS_RD_END, 32'(15 + n));
    wr(SET, bitw(`UBM_SET_READ_RUN) | (32'(eop) << `UBM_SET_EOP_EN));
    wait_run(`UBM_SET_READ_RUN);
    chk(32'(far_u.n_in), 32'(n));
    for (int i = 0; i < n; i++) begin
      chk(32'(far_u.in_b[i]), 32'(far_u.mem[16 + i]));
      chk(32'(far_u.in_l[i]), 32'(eop && i == n - 1));
    end
    rd(IS, bitw(`UBM_IRQ_READ_END));
    rd(`UBM_OFS_STATUS, 32'h0);
    far_u.n_in <= 0;
    rd(`UBM_OFS_STATUS, bitw(`UBM_STS_RD_EMPTY));
  endtask : run_read
  task automatic end_sim();
    if (num_errors == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim
  // Cut a hang short far beyond the few hundred cycles the scenarios need
  initial begin
    repeat (60000) @(posedge hclk);
    num_errors++;
    end_sim();
  end
  // Reset for ten cycles, then work through the scenarios
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 11; i++) rd(8'(4 * i), (i == 8) ? 32'h1 : `UBM_RST_WORD);
    wr(8'h3c, 32'hffffffff);
    rd(8'h3c, 32'h0);
    run_read(7, 1'b1);
    chk(32'(usb_irq_out), 32'h0);
    wr(`UBM_OFS_IRQ_EN, bitw(`UBM_IRQ_READ_END));
    @(negedge hclk);
    chk(32'(usb_irq_out), 32'h1);
    wr(IS, 32'hf);
    @(negedge hclk);
    chk(32'(usb_irq_out), 32'h0);
    wr(`UBM_OFS_IRQ_EN, 32'h0);
    run_read(5, 1'b0);
    wr(IS, 32'hf);
    wr(`UBM_OFS_RD_START, 32'h20);
    wr(`UBM_OFS_RD_END, 32'hff);
    wr(SET, bitw(`UBM_SET_READ_RUN));
    repeat (30) @(posedge hclk);
    wr(SET, bitw(`UBM_SET_READ_STOP));
    wait_run(`UBM_SET_READ_RUN);
    bus(1'b0, `UBM_OFS_RD_CUR, 32'h0);
    chk(32'(rv > 32'h20 && rv < 32'hff), 32'h1);
    rd(IS, 32'h0);
    wr(SET, bitw(`UBM_SET_READ_INIT));
    rd(`UBM_OFS_RD_CUR, 32'h0);
    rd(`UBM_OFS_RD_START, 32'h20);
    far_u.n_in <= 0;
    fill(6);
    wr(`UBM_OFS_WR_START, 32'h80);
    wr(`UBM_OFS_WR_END, 32'h85);
    wr(SET, bitw(`UBM_SET_WRITE_RUN));
    wait_run(`UBM_SET_WRITE_RUN);
    for (int i = 0; i < 6; i++) chk(32'(far_u.mem[128 + i]), 32'(exp_w[i]));
    rd(`UBM_OFS_WR_CUR, 32'h85);
    rd(IS, bitw(`UBM_IRQ_WRITE_END));
    wr(IS, 32'hf);
    far_u.send_pkt();
    rd(IS, bitw(`UBM_IRQ_START_NEEDED));
    wr(IS, 32'hf);
    wr(`UBM_OFS_EXPIRE, bitw(`UBM_EXP_EN_BIT) | 32'd40);
    fill(3);
    wr(`UBM_OFS_WR_START, 32'ha0);
    wr(`UBM_OFS_WR_END, 32'hff);
    wr(SET, bitw(`UBM_SET_WRITE_RUN));
    repeat (4) begin
      repeat (25) @(posedge hclk);
      far_u.send_pkt();
    end
    bus(1'b0, SET, 32'h0);
    chk(32'(rv[`UBM_SET_WRITE_RUN]), 32'h1);
    wait_run(`UBM_SET_WRITE_RUN);
    for (int i = 0; i < 3; i++) chk(32'(far_u.mem[160 + i]), 32'(exp_w[i]));
    rd(`UBM_OFS_WR_CUR, 32'ha2);
    rd(IS, bitw(`UBM_IRQ_WRITE_EXPIRE));
    wr(IS, 32'hf);
    wr(`UBM_OFS_EXPIRE, 32'h0);
    wr(`UBM_OFS_WR_START, 32'hc0);
    wr(SET, bitw(`UBM_SET_WRITE_RUN));
    wr(SET, bitw(`UBM_SET_WRITE_STOP));
    wait_run(`UBM_SET_WRITE_RUN);
    rd(IS, 32'h0);
    wr(SET, bitw(`UBM_SET_WRITE_INIT));
    rd(`UBM_OFS_WR_CUR, 32'h0);
    rd(`UBM_OFS_RD_START, 32'h20);
    end_sim();
  end
endmodule : testbench
